/* File: fas_pkg.sv */
/*
   fas_pkg: register map, field positions, command codes, sector-map constants,
   and the decode helpers shared by the address map and its link receiver.
   assumes a 64 MB array split into 256 KB blocks and APB with 32-bit data.
*/

package fas_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] FAS_OFS_CFG = 8'h00;
   localparam logic [7:0] FAS_OFS_PROBE = 8'h04;
   localparam logic [7:0] FAS_OFS_PRES = 8'h08;
   localparam logic [7:0] FAS_OFS_LCMD = 8'h0C;
   localparam logic [7:0] FAS_OFS_LADR = 8'h10;
   localparam int FAS_CFG_EXT = 0;
   localparam int FAS_CFG_UNI = 1;
   localparam int FAS_CFG_TOP = 2;
   localparam int FAS_CFG_EXTNV = 3;
   localparam logic FAS_UNI_RST = 1'b0;
   localparam logic FAS_EXT_RST = 1'b0;
   localparam logic [31:0] FAS_PROBE_RST = 32'h0000_0000;
   localparam int FAS_PRES_PAR = 9;
   localparam int FAS_PRES_OOR = 10;
   localparam int FAS_LCMD_GO = 8;
   localparam int FAS_LCMD_REJ = 9;
   localparam int FAS_LCMD_A32 = 10;

   // ----------------------------------------------------------------
   // commands, counts, sector map
   // ----------------------------------------------------------------
   localparam logic [7:0] FAS_CMD_P4E = 8'h20;
   localparam logic [7:0] FAS_CMD_P4E4 = 8'h21;
   localparam logic [7:0] FAS_CMD_BE = 8'hD8;
   localparam logic [7:0] FAS_CMD_BE4 = 8'hDC;
   localparam logic [5:0] FAS_CNT_CMD = 6'h07;
   localparam logic [5:0] FAS_CNT_END3 = 6'h1F;
   localparam logic [5:0] FAS_CNT_END4 = 6'h27;
   localparam logic [1:0] FAS_LD_AT = 2'h2;
   localparam logic [1:0] FAS_LD_DONE = 2'h3;
   localparam logic [8:0] FAS_KB_BLK = 9'h100;
   localparam logic [8:0] FAS_KB_MID = 9'h0E0;
   localparam logic [8:0] FAS_KB_PAR = 9'h004;
   localparam logic [8:0] FAS_PAR_CNT = 9'h008;
   localparam logic [8:0] FAS_TOP_IDX0 = 9'h100;
   localparam logic [7:0] FAS_BLK_FIRST = 8'h00;
   localparam logic [7:0] FAS_BLK_LAST = 8'hFF;
   localparam logic [2:0] FAS_PAR_BOT = 3'h0;
   localparam logic [2:0] FAS_PAR_TOP = 3'h7;
   localparam logic [31:0] FAS_MID_BASE = 32'h0000_8000;

   typedef struct packed {
      logic [8:0] idx;
      logic par;
      logic oor;
      logic [31:0] base;
      logic [8:0] kb;
   } fas_sec_t;

   typedef enum logic [1:0] {
      FAS_RX_CMD = 2'b00,
      FAS_RX_ADR = 2'b01,
      FAS_RX_END = 2'b11
   } fas_rx_t;

   function automatic logic fas_is_4b(input logic [7:0] c);
      return (c == FAS_CMD_P4E4) || (c == FAS_CMD_BE4);
   endfunction : fas_is_4b

   function automatic logic fas_is_par(input logic [7:0] c);
      return (c == FAS_CMD_P4E) || (c == FAS_CMD_P4E4);
   endfunction : fas_is_par

   function automatic logic fas_is_blk(input logic [7:0] c);
      return (c == FAS_CMD_BE) || (c == FAS_CMD_BE4);
   endfunction : fas_is_blk

   // only a[31:12] matter: the in-sector offset never picks a sector
   function automatic fas_sec_t fas_decode(
      input logic [31:0] a,
      input logic uni,
      input logic top
   );
      fas_sec_t s;
      logic [7:0] blk;
      blk = a[25:18];
      s.oor = |a[31:26];
      s.par = 1'b0;
      s.idx = {1'b0, blk};
      s.base = {6'h00, blk, 18'h0_0000};
      s.kb = FAS_KB_BLK;
      if (!uni && !top)
      begin
         s.idx = {1'b0, blk} + FAS_PAR_CNT;
         if (blk == FAS_BLK_FIRST)
         begin
            s.idx = FAS_PAR_CNT;
            s.base = FAS_MID_BASE;
            s.kb = FAS_KB_MID;
            if (a[17:15] == FAS_PAR_BOT)
            begin
               s.par = 1'b1;
               s.idx = {6'h00, a[14:12]};
               s.base = {6'h00, a[25:12], 12'h000};
               s.kb = FAS_KB_PAR;
            end
         end
      end
      else if (!uni && (blk == FAS_BLK_LAST))
      begin
         s.kb = FAS_KB_MID;
         if (a[17:15] == FAS_PAR_TOP)
         begin
            s.par = 1'b1;
            s.idx = FAS_TOP_IDX0 | {6'h00, a[14:12]};
            s.base = {6'h00, a[25:12], 12'h000};
            s.kb = FAS_KB_PAR;
         end
      end
      return s;
   endfunction : fas_decode

endpackage : fas_pkg

/* File: fas_link_rx.sv */
/*
   fas_link_rx: link-side receiver, clocked by the host serial clock.
   assumes mosi is launched on the far sclk edge; cs_n high ends each frame.
*/
`timescale 1ns/1ps
`default_nettype none

module fas_link_rx (
   input wire logic sclk, // link clock from the host
   input wire logic presetn, // system reset, active low
   input wire logic cs_n, // frame select, active low
   input wire logic mosi, // serial data from the host
   input wire logic ext_mode, // extended-address bit, pclk domain level
   output logic [7:0] hold_cmd, // last command byte
   output logic [31:0] hold_addr, // last address, zero-extended
   output logic hold_a32, // last address was four bytes
   output logic done_tgl // flips once per completed header
);
   import fas_pkg::*;

   wire logic frm_rst_n;
   fas_rx_t st_r, st_nxt;
   logic [5:0] cnt_r, cnt_nxt;
   logic [31:0] sh_r;
   logic [7:0] cmd_r, cmd_nxt;
   logic a32_r, a32_nxt;
   logic ext1_r, ext2_r;
   logic [7:0] hc_nxt;
   logic [31:0] ha_nxt;
   logic hx_nxt, tg_nxt;
   logic [7:0] cmd_w;

   // frame state dies with cs_n, so a stopped sclk leaves nothing stale
   assign frm_rst_n = presetn & ~cs_n;
   assign cmd_w = {sh_r[6:0], mosi};

   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      cmd_nxt = cmd_r;
      a32_nxt = a32_r;
      hc_nxt = hold_cmd;
      ha_nxt = hold_addr;
      hx_nxt = hold_a32;
      tg_nxt = done_tgl;
      case (st_r)
         FAS_RX_CMD:
         begin
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_r == FAS_CNT_CMD)
            begin
               st_nxt = FAS_RX_ADR;
               cmd_nxt = cmd_w;
               a32_nxt = fas_is_4b(cmd_w) | ext2_r;
            end
         end
         FAS_RX_ADR:
         begin
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_r == (a32_r ? FAS_CNT_END4 : FAS_CNT_END3))
            begin
               st_nxt = FAS_RX_END;
               hc_nxt = cmd_r;
               hx_nxt = a32_r;
               tg_nxt = ~done_tgl;
               if (a32_r)
                  ha_nxt = {sh_r[30:0], mosi};
               else
                  ha_nxt = {8'h00, sh_r[22:0], mosi};
            end
         end
         FAS_RX_END: ;
         default: st_nxt = FAS_RX_CMD;
      endcase
   end

   always_ff @(posedge sclk or negedge frm_rst_n)
   begin
      if (!frm_rst_n)
      begin
         st_r <= FAS_RX_CMD;
         cnt_r <= 6'h00;
         sh_r <= 32'h0000_0000;
         cmd_r <= 8'h00;
         a32_r <= 1'b0;
         ext1_r <= 1'b0;
         ext2_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= {sh_r[30:0], mosi};
         cmd_r <= cmd_nxt;
         a32_r <= a32_nxt;
         ext1_r <= ext_mode;
         ext2_r <= ext1_r;
      end
   end

   // held words change once per frame; the toggle tells pclk when to look
   always_ff @(posedge sclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hold_cmd <= 8'h00;
         hold_addr <= 32'h0000_0000;
         hold_a32 <= 1'b0;
         done_tgl <= 1'b0;
      end
      else
      begin
         hold_cmd <= hc_nxt;
         hold_addr <= ha_nxt;
         hold_a32 <= hx_nxt;
         done_tgl <= tg_nxt;
      end
   end

   addr_len_a: assert property (@(posedge sclk) disable iff (!frm_rst_n)
      (st_r == FAS_RX_CMD && cnt_r == FAS_CNT_CMD)
      |=> (a32_r == (fas_is_4b(cmd_r) | $past(ext2_r))))
      else $error("address length chosen wrongly");

   zero_fill_a: assert property (@(posedge sclk) disable iff (!presetn)
      $changed(done_tgl) |-> (hold_a32 || hold_addr[31:24] == 8'h00))
      else $error("three-byte address not zero-extended");

endmodule : fas_link_rx

`default_nettype wire

/* File: fas_addr_map.sv */
/*
   fas_addr_map: address length selection and sector-map decode, with an
   APB register file; the serial header arrives on its own sclk domain.
   assumes nv_* pins carry the non-volatile configuration copies.
*/
`timescale 1ns/1ps
`default_nettype none

module fas_addr_map (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic sclk, // link clock
   input wire logic cs_n, // frame select, active low
   input wire logic mosi, // serial data in
   input wire logic nv_ext_addr, // non-volatile extended-address default
   input wire logic nv_param_top, // parameter_location_nv_bit
   output logic cmd_valid, // pulse: new command header
   output logic [7:0] cmd_code, // command byte
   output logic [31:0] cmd_addr, // internal 32-bit array address
   output logic cmd_addr32, // header carried four address bytes
   output logic erase_go, // pulse: erase accepted
   output logic erase_reject, // pulse: erase has no effect
   output logic [8:0] erase_sector, // physical sector index
   output logic [31:0] erase_base, // sector start address
   output logic [8:0] erase_kb // sector size in KB
);
   import fas_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic nvx1_r, nvx2_r, nvt1_r, nvt2_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         nvx1_r <= 1'b0;
         nvx2_r <= 1'b0;
         nvt1_r <= 1'b0;
         nvt2_r <= 1'b0;
      end
      else
      begin
         nvx1_r <= nv_ext_addr;
         nvx2_r <= nvx1_r;
         nvt1_r <= nv_param_top;
         nvt2_r <= nvt1_r;
      end
   end

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   logic [1:0] ld_cnt_r, ld_cnt_nxt;
   logic cfg_ext_r, cfg_ext_nxt;
   logic cfg_uni_r, cfg_uni_nxt;
   logic [31:0] probe_r, probe_nxt;
   fas_sec_t pres_r, pres_nxt;
   logic [31:0] rd_val;
   logic rd_hit;
   logic wr_en, setup;
   logic [31:0] prdata_r, prdata_nxt;
   logic pslverr_r, pslverr_nxt;
   logic lgo_r, lgo_nxt, lrej_r, lrej_nxt;
   logic cmd_valid_r;
   logic [7:0] cmd_code_r;
   logic [31:0] cmd_addr_r;
   logic cmd_a32_r;

   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pwrite;

   always_comb
   begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      case (paddr)
         FAS_OFS_CFG:
         begin
            rd_val[FAS_CFG_EXT] = cfg_ext_r;
            rd_val[FAS_CFG_UNI] = cfg_uni_r;
            rd_val[FAS_CFG_TOP] = nvt2_r;
            rd_val[FAS_CFG_EXTNV] = nvx2_r;
         end
         FAS_OFS_PROBE: rd_val = probe_r;
         FAS_OFS_PRES:
         begin
            rd_val[8:0] = pres_r.idx;
            rd_val[FAS_PRES_PAR] = pres_r.par;
            rd_val[FAS_PRES_OOR] = pres_r.oor;
         end
         FAS_OFS_LCMD:
         begin
            rd_val[7:0] = cmd_code_r;
            rd_val[FAS_LCMD_GO] = lgo_r;
            rd_val[FAS_LCMD_REJ] = lrej_r;
            rd_val[FAS_LCMD_A32] = cmd_a32_r;
         end
         FAS_OFS_LADR: rd_val = cmd_addr_r;
         default: rd_hit = 1'b0;
      endcase
   end

   // the volatile copy loads the non-volatile pin once, when the sync has settled
   always_comb
   begin
      ld_cnt_nxt = ld_cnt_r;
      cfg_ext_nxt = cfg_ext_r;
      cfg_uni_nxt = cfg_uni_r;
      probe_nxt = probe_r;
      if (ld_cnt_r != FAS_LD_DONE)
         ld_cnt_nxt = ld_cnt_r + 2'h1;
      if (wr_en)
      begin
         case (paddr)
            FAS_OFS_CFG:
            begin
               cfg_ext_nxt = pwdata[FAS_CFG_EXT];
               cfg_uni_nxt = pwdata[FAS_CFG_UNI];
            end
            FAS_OFS_PROBE: probe_nxt = pwdata;
            default: ;
         endcase
      end
      if (ld_cnt_r == FAS_LD_AT)
         cfg_ext_nxt = nvx2_r;
   end

   // read data is registered in the setup phase: zero wait states
   always_comb
   begin
      prdata_nxt = prdata_r;
      pslverr_nxt = pslverr_r;
      if (setup)
      begin
         prdata_nxt = pwrite ? 32'h0000_0000 : rd_val;
         pslverr_nxt = ~rd_hit;
      end
   end

   assign pres_nxt = fas_decode(probe_r, cfg_uni_r, nvt2_r);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ld_cnt_r <= 2'h0;
         cfg_ext_r <= FAS_EXT_RST;
         cfg_uni_r <= FAS_UNI_RST;
         probe_r <= FAS_PROBE_RST;
         pres_r <= '0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else
      begin
         ld_cnt_r <= ld_cnt_nxt;
         cfg_ext_r <= cfg_ext_nxt;
         cfg_uni_r <= cfg_uni_nxt;
         probe_r <= probe_nxt;
         pres_r <= pres_nxt;
         prdata_r <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pslverr = pslverr_r;
   assign pready = 1'b1;

   // ----------------------------------------------------------------
   // link crossing
   // ----------------------------------------------------------------
   logic [7:0] hold_cmd;
   logic [31:0] hold_addr;
   logic hold_a32, done_tgl;
   logic tg1_r, tg2_r, tg3_r;
   logic new_w;
   logic [7:0] cmd_code_nxt;
   logic [31:0] cmd_addr_nxt;
   logic cmd_a32_nxt;

   fas_link_rx u_rx (
      .sclk(sclk),
      .presetn(presetn),
      .cs_n(cs_n),
      .mosi(mosi),
      .ext_mode(cfg_ext_r),
      .hold_cmd(hold_cmd),
      .hold_addr(hold_addr),
      .hold_a32(hold_a32),
      .done_tgl(done_tgl)
   );

   // held words are stable long before the next toggle can arrive
   assign new_w = tg2_r ^ tg3_r;

   always_comb
   begin
      cmd_code_nxt = cmd_code_r;
      cmd_addr_nxt = cmd_addr_r;
      cmd_a32_nxt = cmd_a32_r;
      if (new_w)
      begin
         cmd_code_nxt = hold_cmd;
         cmd_addr_nxt = hold_addr;
         cmd_a32_nxt = hold_a32;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tg1_r <= 1'b0;
         tg2_r <= 1'b0;
         tg3_r <= 1'b0;
         cmd_valid_r <= 1'b0;
         cmd_code_r <= 8'h00;
         cmd_addr_r <= 32'h0000_0000;
         cmd_a32_r <= 1'b0;
      end
      else
      begin
         tg1_r <= done_tgl;
         tg2_r <= tg1_r;
         tg3_r <= tg2_r;
         cmd_valid_r <= new_w;
         cmd_code_r <= cmd_code_nxt;
         cmd_addr_r <= cmd_addr_nxt;
         cmd_a32_r <= cmd_a32_nxt;
      end
   end

   assign cmd_valid = cmd_valid_r;
   assign cmd_code = cmd_code_r;
   assign cmd_addr = cmd_addr_r;
   assign cmd_addr32 = cmd_a32_r;

   // ----------------------------------------------------------------
   // erase target
   // ----------------------------------------------------------------
   fas_sec_t sec_c;
   logic ok_c;
   logic go_r, go_nxt, rej_r, rej_nxt;
   logic [8:0] es_r, es_nxt, ek_r, ek_nxt;
   logic [31:0] eb_r, eb_nxt;

   assign sec_c = fas_decode(cmd_addr_r, cfg_uni_r, nvt2_r);

   // an erase of the wrong kind for its sector does nothing and is flagged
   always_comb
   begin
      ok_c = 1'b0;
      go_nxt = 1'b0;
      rej_nxt = 1'b0;
      lgo_nxt = lgo_r;
      lrej_nxt = lrej_r;
      es_nxt = es_r;
      eb_nxt = eb_r;
      ek_nxt = ek_r;
      if (fas_is_par(cmd_code_r))
         ok_c = sec_c.par & ~sec_c.oor;
      else if (fas_is_blk(cmd_code_r))
         ok_c = ~sec_c.par & ~sec_c.oor;
      if (cmd_valid_r)
      begin
         lgo_nxt = 1'b0;
         lrej_nxt = 1'b0;
         if (fas_is_par(cmd_code_r) || fas_is_blk(cmd_code_r))
         begin
            go_nxt = ok_c;
            rej_nxt = ~ok_c;
            lgo_nxt = ok_c;
            lrej_nxt = ~ok_c;
            if (ok_c)
            begin
               es_nxt = sec_c.idx;
               eb_nxt = sec_c.base;
               ek_nxt = sec_c.kb;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         go_r <= 1'b0;
         rej_r <= 1'b0;
         lgo_r <= 1'b0;
         lrej_r <= 1'b0;
         es_r <= 9'h000;
         eb_r <= 32'h0000_0000;
         ek_r <= 9'h000;
      end
      else
      begin
         go_r <= go_nxt;
         rej_r <= rej_nxt;
         lgo_r <= lgo_nxt;
         lrej_r <= lrej_nxt;
         es_r <= es_nxt;
         eb_r <= eb_nxt;
         ek_r <= ek_nxt;
      end
   end

   assign erase_go = go_r;
   assign erase_reject = rej_r;
   assign erase_sector = es_r;
   assign erase_base = eb_r;
   assign erase_kb = ek_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic [7:0] pb_blk;
   logic pb_bot, pb_top;
   assign pb_blk = probe_r[25:18];
   assign pb_bot = ~cfg_uni_r & ~nvt2_r & (probe_r[25:15] == 11'h000);
   assign pb_top = ~cfg_uni_r & nvt2_r & (probe_r[25:15] == 11'h7FF);

   ext_load_a: assert property (
      (ld_cnt_r == FAS_LD_AT) |=> (cfg_ext_r == $past(nvx2_r)))
      else $error("extended bit not loaded from nv copy");

   legacy_fill_a: assert property (
      (cmd_valid_r && !cmd_a32_r) |-> (cmd_addr_r[31:24] == 8'h00))
      else $error("upper address byte not zero");

   four_byte_a: assert property (
      (cmd_valid_r && fas_is_4b(cmd_code_r)) |-> cmd_a32_r)
      else $error("four-byte command took a short address");

   par_erase_a: assert property (
      (go_r && fas_is_par(cmd_code_r))
      |-> (ek_r == FAS_KB_PAR && eb_r[11:0] == 12'h000 && es_r[7:3] != 5'h01))
      else $error("parameter erase not one aligned 4 KB sector");

   blk_keep_a: assert property (
      go_r |-> !(fas_is_blk(cmd_code_r) && ek_r == FAS_KB_PAR))
      else $error("block erase hit a parameter sector");

   erase_time_a: assert property (
      (cmd_valid_r && (fas_is_par(cmd_code_r) || fas_is_blk(cmd_code_r)))
      |=> (go_r ^ rej_r) ##1 (!go_r && !rej_r))
      else $error("erase outcome missing or repeated");

   uni_map_a: assert property (
      ($past(presetn) && $past(cfg_uni_r))
      |-> (pres_r.idx == {1'b0, $past(pb_blk)} && !pres_r.par))
      else $error("uniform decode wrong");

   bot_map_a: assert property (
      ($past(presetn) && $past(pb_bot)) |-> (pres_r.par && pres_r.idx[8:3] == 6'h00))
      else $error("bottom parameter sector not decoded");

   top_map_a: assert property (
      ($past(presetn) && $past(pb_top)) |-> (pres_r.par && pres_r.idx[8:3] == 6'h20))
      else $error("top parameter sector not decoded");

   apb_err_a: assert property (
      (setup && !rd_hit) |=> pslverr)
      else $error("unmapped access not flagged");

   par_go_c: cover property (go_r && ek_r == FAS_KB_PAR);
   mid_go_c: cover property (go_r && ek_r == FAS_KB_MID);
   reject_c: cover property (rej_r);
   long_cmd_c: cover property (cmd_valid_r && cmd_a32_r && !fas_is_4b(cmd_code_r));

endmodule : fas_addr_map

`default_nettype wire

/* File: fas_spi_host.sv */
/*
   fas_spi_host: host model that sends one command header per frame.
   assumes the device samples mosi on rising sclk, msb first.
*/
`timescale 1ns/1ps
`default_nettype none

module fas_spi_host (
   output logic sclk, // link clock, still outside frames
   output logic cs_n, // frame select, active low
   output logic mosi // serial data
);
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // three-byte frames drop the top address byte
   task automatic send(input logic [7:0] c, input logic [31:0] a, input int nb);
      logic [39:0] v;
      v = (nb == 4) ? {c, a} : {c, a[23:0], 8'h00};
      #7;
      cs_n = 1'b0;
      for (int i = 0; i < 8 + 8 * nb; i++)
      begin
         mosi = v[39 - i];
         #15 sclk = 1'b1;
         #15 sclk = 1'b0;
      end
      mosi = ~mosi; // released line must not keep the last bit
      cs_n = 1'b1;
      #30;
   endtask : send
endmodule : fas_spi_host
`default_nettype wire

/* File: fas_addr_map_tb.sv */
/*
   fas_addr_map_tb: apb and link header tests of the sector map.
   assumes zero-wait apb and the host model for the link.
*/
`timescale 1ns/1ps
`default_nettype none

module fas_addr_map_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, cmd_addr, erase_base;
   logic pready, pslverr, sclk, cs_n, mosi, nv_ext = 0, nv_top = 0;
   logic cmd_valid, cmd_addr32, erase_go, erase_reject;
   logic [7:0] cmd_code;
   logic [8:0] erase_sector, erase_kb;
   int err_count = 0, comparisons = 0, cyc = 0, vld_count = 0;
   logic [31:0] d;
   logic e;

   always #12.5 pclk = ~pclk;

   fas_spi_host host_u (.sclk(sclk), .cs_n(cs_n), .mosi(mosi));
   fas_addr_map dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
      .cs_n(cs_n), .mosi(mosi), .nv_ext_addr(nv_ext), .nv_param_top(nv_top),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
      .cmd_addr32(cmd_addr32), .erase_go(erase_go), .erase_reject(erase_reject),
      .erase_sector(erase_sector), .erase_base(erase_base), .erase_kb(erase_kb));

   task automatic close_out();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out

   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         close_out();
      end
   end

   // header pulses are counted mid-cycle, where they stand settled
   always @(negedge pclk)
   begin
      if (cmd_valid === 1'b1)
         vld_count++;
   end

   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      comparisons++;
      if (g !== x)
      begin
         $display("BAD %s exp %h got %h", n, x, g);
         err_count++;
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rst();
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
   endtask : rst

   task automatic hdr(input logic [7:0] c, input logic [31:0] a, input int nb,
         input logic go, input logic [8:0] s, input logic [8:0] kb, input logic [31:0] b);
      int n, v0;
      n = 0;
      v0 = vld_count;
      host_u.send(c, a, nb);
      while (erase_go !== 1'b1 && erase_reject !== 1'b1 && n < 40)
      begin
         @(posedge pclk);
         #1;
         n++;
      end
      chk("vld", v0 + 1, vld_count);
      chk("go", {31'h0, go}, {31'h0, erase_go});
      chk("rej", {31'h0, ~go}, {31'h0, erase_reject});
      chk("code", {24'h0, c}, {24'h0, cmd_code});
      chk("a32", {31'h0, nb == 4}, {31'h0, cmd_addr32});
      chk("adr", (nb == 4) ? a : {8'h00, a[23:0]}, cmd_addr);
      if (go)
      begin
         chk("sec", {23'h0, s}, {23'h0, erase_sector});
         chk("kb", {23'h0, kb}, {23'h0, erase_kb});
         chk("base", b, erase_base);
      end
   endtask : hdr

   initial
   begin
      rst();
      apb(1'b0, 8'h00, 0);
      chk("cfg", 32'h0000_0000, d);
      apb(1'b0, 8'h40, 0);
      chk("err", 32'h0000_0001, {31'h0, e});
      hdr(8'hD8, 32'h0004_0000, 3, 1, 9'h009, 9'h100, 32'h0004_0000);
      hdr(8'h20, 32'h0000_7ABC, 3, 1, 9'h007, 9'h004, 32'h0000_7000);
      hdr(8'hD8, 32'h0000_1000, 3, 0, 9'h000, 9'h000, 32'h0000_0000);
      hdr(8'hD8, 32'h0000_8000, 3, 1, 9'h008, 9'h0E0, 32'h0000_8000);
      hdr(8'hDC, 32'h03FC_1234, 4, 1, 9'h107, 9'h100, 32'h03FC_0000);
      apb(1'b1, 8'h00, 32'h0000_0001);
      hdr(8'hD8, 32'h0100_0000, 4, 1, 9'h048, 9'h100, 32'h0100_0000);
      apb(1'b1, 8'h00, 32'h0000_0002);
      hdr(8'h20, 32'h0000_0000, 3, 0, 9'h000, 9'h000, 32'h0000_0000);
      hdr(8'hD8, 32'h0000_1000, 3, 1, 9'h000, 9'h100, 32'h0000_0000);
      @(posedge pclk);
      nv_ext <= 1'b1;
      nv_top <= 1'b1;
      rst();
      apb(1'b0, 8'h00, 0);
      chk("cfg", 32'h0000_000D, d);
      hdr(8'hD8, 32'h03FF_0000, 4, 1, 9'h0FF, 9'h0E0, 32'h03FC_0000);
      hdr(8'h21, 32'h03FF_F000, 4, 1, 9'h107, 9'h004, 32'h03FF_F000);
      apb(1'b0, 8'h0C, 0);
      chk("lcmd", 32'h0000_0521, d);
      apb(1'b0, 8'h10, 0);
      chk("ladr", 32'h03FF_F000, d);
      apb(1'b1, 8'h04, 32'h03FF_9ABC);
      apb(1'b0, 8'h08, 0);
      chk("pres", 32'h0000_0301, d);
      apb(1'b1, 8'h04, 32'h0400_0000);
      apb(1'b0, 8'h08, 0);
      chk("pres", 32'h0000_0400, d);
      close_out();
   end
endmodule : fas_addr_map_tb
`default_nettype wire
